// File: cnse_pkg.sv
// constants, encodings and carrier types for the node status and emergency block
package cnse_pkg;

  // ----------------------------------------------------------------
  // object dictionary indices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_DEVICE_TYPE = 16'h1000; // device_type_word
  localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001; // error_summary_register
  localparam logic [15:0] IDX_BUS_STATUS = 16'h1002; // bus_state_status_word
  localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003; // error history list
  localparam logic [15:0] IDX_EMCY_COB = 16'h1014; // emergency identifier
  localparam logic [15:0] IDX_HB_TIME = 16'h1017; // heartbeat producer time, ms

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] DEVICE_TYPE_VALUE = 32'h0000_0000; // always zero
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000; // status word reset value
  localparam int STATUS_ERR_BIT = 7; // generic error copy in status word
  localparam int ERR_GENERIC_BIT = 0; // generic error in error summary
  localparam logic [15:0] HB_TIME_RESET = 16'h0000; // heartbeat off after reset
  localparam logic [6:0] NODE_ID_DEFAULT = 7'h3f; // factory address 63
  localparam logic [6:0] NODE_ID_MIN = 7'h01; // lowest legal address
  localparam logic [6:0] NODE_ID_MAX = 7'h7f; // highest legal address
  localparam logic [3:0] BITRATE_COUNT = 4'h9; // nine selectable rates
  localparam logic [3:0] BITRATE_DEFAULT = 4'h6; // 500 kbps
  localparam int HIST_DEPTH = 8; // stored error history entries
  localparam int SDO_CHANNELS = 2; // master plus diagnostics server
  localparam int TPDO_CHANNELS = 4; // transmit process-data channels
  localparam int RPDO_CHANNELS = 2; // receive process-data channels

  // ----------------------------------------------------------------
  // fixed identifiers and command codes
  // ----------------------------------------------------------------
  localparam logic [10:0] NMT_COB = 11'h000; // network-management commands
  localparam logic [10:0] SYNC_COB = 11'h080; // synchronisation, consumed only
  localparam logic [10:0] EMCY_COB_BASE = 11'h080; // emergency default base
  localparam logic [10:0] ERRCTL_COB_BASE = 11'h700; // boot-up, guard, heartbeat
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RESET_NODE = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000; // ref_clk rate
  localparam int HB_UNIT_US = 1000; // heartbeat time unit, 1 ms
  localparam int HB_UNIT_CYCLES = CLK_HZ / 1_000_000 * HB_UNIT_US; // cycles per ms

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_PREOP = 3'b101,
    ST_OPER = 3'b110,
    ST_STOPPED = 3'b111
  } cnse_state_type;

  typedef enum logic [1:0] {
    CFG_NODE_ID = 2'b00,
    CFG_BITRATE = 2'b01,
    CFG_SDO2_EN = 2'b10
  } cnse_cfg_sel_type;

  typedef struct packed {
    logic rtr;
    logic [10:0] cob;
    logic [3:0] dlc;
    logic [63:0] data; // byte 0 in bits 7:0
  } cnse_frame_type;

  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } cnse_od_req_type;

endpackage

// File: cnse_node.sv
// node status, error control and emergency logic of the field-bus slave
module cnse_node #(
  parameter int HB_TICK_CYCLES = cnse_pkg::HB_UNIT_CYCLES // cycles per heartbeat ms
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_valid, // received frame strobe
  input cnse_pkg::cnse_frame_type rx_frame,
  output cnse_pkg::cnse_frame_type tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic od_req, // object dictionary access strobe
  input cnse_pkg::cnse_od_req_type od_cmd,
  output logic od_ack,
  output logic od_abort,
  output logic [31:0] od_rdata,
  input wire logic err_evt, // process-data or exchange error
  input wire logic [15:0] err_code,
  input wire logic cfg_wr, // serial service port write
  input cnse_pkg::cnse_cfg_sel_type cfg_sel,
  input wire logic [7:0] cfg_wdata,
  output logic cfg_ack,
  output logic cfg_nak,
  output logic [6:0] node_id,
  output logic [3:0] bitrate_sel,
  output logic sdo2_enable,
  output logic [1:0] sdo_channels,
  output logic [2:0] tpdo_channels,
  output logic [1:0] rpdo_channels,
  output logic sync_pulse,
  output logic err_tpdo_evt,
  output logic [31:0] status_word
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    cnse_pkg::cnse_state_type state; // bus state
    logic boot_pend; // boot-up frame waiting
    logic emcy_pend; // emergency frame waiting
    logic guard_pend; // guard answer waiting
    logic hb_pend; // heartbeat waiting
    logic toggle; // guard toggle bit
    logic [15:0] hb_time; // producer time in ms
    logic [23:0] tick_cnt; // cycles within current ms
    logic [15:0] ms_cnt; // ms since last heartbeat
    logic emcy_custom; // master has written the identifier
    logic [10:0] emcy_cob; // written identifier
    logic [15:0] emcy_code; // code of newest entry
    logic [3:0] err_cnt; // entries stored
    logic [cnse_pkg::HIST_DEPTH-1:0][15:0] hist; // newest first
    logic [6:0] node_id;
    logic [3:0] bitrate;
    logic sdo2_en;
    cnse_pkg::cnse_frame_type tx_frame;
    logic tx_valid;
    logic od_ack;
    logic od_abort;
    logic [31:0] od_rdata;
    logic cfg_ack;
    logic cfg_nak;
    logic sync_pulse;
    logic err_evt;
    logic [31:0] status;
  } cnse_node_state_type;

  cnse_node_state_type st_q;
  cnse_node_state_type st_d;

  logic generic_err; // any error recorded
  logic [10:0] emcy_id; // identifier in use
  logic [10:0] errctl_id; // boot-up, guard and heartbeat identifier
  logic hb_tick; // last cycle of a ms
  logic nmt_hit; // command for this node
  logic [3:0] hist_last; // index of a history read

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // generic error is present while the history holds anything
  assign generic_err = (st_q.err_cnt != 4'h0);
  // default identifier follows the node address until overwritten
  assign emcy_id = st_q.emcy_custom ? st_q.emcy_cob :
                   (cnse_pkg::EMCY_COB_BASE + {4'h0, st_q.node_id});
  assign errctl_id = cnse_pkg::ERRCTL_COB_BASE + {4'h0, st_q.node_id};
  assign hb_tick = (st_q.tick_cnt == 24'(HB_TICK_CYCLES - 1));
  // fixed identifier and payload layout, nothing the master can change
  assign nmt_hit = rx_valid && !rx_frame.rtr && (rx_frame.cob == cnse_pkg::NMT_COB) &&
                   (rx_frame.data[15:8] == 8'h00 ||
                    rx_frame.data[15:8] == {1'b0, st_q.node_id});
  assign hist_last = od_cmd.sub[3:0] - 4'h1;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.od_ack = 1'b0;
    st_d.od_abort = 1'b0;
    st_d.cfg_ack = 1'b0;
    st_d.cfg_nak = 1'b0;
    st_d.sync_pulse = 1'b0;
    st_d.err_evt = 1'b0;

    // heartbeat timer runs only with a non-zero producer time
    if (st_q.hb_time == 16'h0000 || st_q.state == cnse_pkg::ST_INIT)
    begin
      st_d.tick_cnt = 24'h0;
      st_d.ms_cnt = 16'h0;
    end
    else if (hb_tick)
    begin
      st_d.tick_cnt = 24'h0;
      if (st_q.ms_cnt + 16'h1 >= st_q.hb_time)
      begin
        st_d.ms_cnt = 16'h0;
        st_d.hb_pend = 1'b1;
      end
      else
      begin
        st_d.ms_cnt = st_q.ms_cnt + 16'h1;
      end
    end
    else
    begin
      st_d.tick_cnt = st_q.tick_cnt + 24'h1;
    end

    // initialisation ends in pre-operational and announces boot-up
    if (st_q.state == cnse_pkg::ST_INIT)
    begin
      st_d.state = cnse_pkg::ST_PREOP;
      st_d.boot_pend = 1'b1;
      st_d.hb_pend = 1'b0;
      st_d.toggle = 1'b0;
    end

    // received frames; emergencies from others match nothing here
    if (nmt_hit)
    begin
      case (rx_frame.data[7:0])
        cnse_pkg::NMT_START: st_d.state = cnse_pkg::ST_OPER;
        cnse_pkg::NMT_STOP: st_d.state = cnse_pkg::ST_STOPPED;
        cnse_pkg::NMT_PREOP: st_d.state = cnse_pkg::ST_PREOP;
        cnse_pkg::NMT_RESET_COMM:
        begin
          st_d.state = cnse_pkg::ST_INIT;
          st_d.hb_time = cnse_pkg::HB_TIME_RESET;
          st_d.emcy_custom = 1'b0;
        end
        cnse_pkg::NMT_RESET_NODE:
        begin
          st_d.state = cnse_pkg::ST_INIT;
          st_d.hb_time = cnse_pkg::HB_TIME_RESET;
          st_d.emcy_custom = 1'b0;
          st_d.err_cnt = 4'h0;
        end
        default: st_d.state = st_q.state; // unknown command ignored
      endcase
    end
    else if (rx_valid && rx_frame.rtr && rx_frame.cob == errctl_id &&
             st_q.hb_time == 16'h0000 && st_q.state != cnse_pkg::ST_INIT)
    begin
      st_d.guard_pend = 1'b1;
    end
    else if (rx_valid && !rx_frame.rtr && rx_frame.cob == cnse_pkg::SYNC_COB)
    begin
      st_d.sync_pulse = 1'b1;
    end

    // object dictionary access, answered one cycle later
    if (od_req)
    begin
      st_d.od_ack = 1'b1;
      st_d.od_rdata = 32'h0;
      if (!od_cmd.wr)
      begin
        case (od_cmd.index)
          cnse_pkg::IDX_DEVICE_TYPE: st_d.od_rdata = cnse_pkg::DEVICE_TYPE_VALUE;
          cnse_pkg::IDX_ERROR_SUMMARY: st_d.od_rdata = {31'h0, generic_err};
          cnse_pkg::IDX_BUS_STATUS: st_d.od_rdata = st_q.status;
          cnse_pkg::IDX_ERROR_HISTORY:
          begin
            if (od_cmd.sub == 8'h00)
              st_d.od_rdata = {28'h0, st_q.err_cnt};
            else if (od_cmd.sub <= {4'h0, st_q.err_cnt})
              st_d.od_rdata = {16'h0, st_q.hist[hist_last[2:0]]};
            else
              st_d.od_abort = 1'b1;
          end
          cnse_pkg::IDX_EMCY_COB: st_d.od_rdata = {21'h0, emcy_id};
          cnse_pkg::IDX_HB_TIME: st_d.od_rdata = {16'h0, st_q.hb_time};
          default: st_d.od_abort = 1'b1;
        endcase
      end
      else
      begin
        case (od_cmd.index)
          cnse_pkg::IDX_ERROR_HISTORY:
          begin
            if (od_cmd.sub == 8'h00 && od_cmd.wdata == 32'h0)
              st_d.err_cnt = 4'h0;
            else
              st_d.od_abort = 1'b1;
          end
          cnse_pkg::IDX_EMCY_COB:
          begin
            st_d.emcy_custom = 1'b1;
            st_d.emcy_cob = od_cmd.wdata[10:0];
          end
          cnse_pkg::IDX_HB_TIME:
          begin
            st_d.hb_time = od_cmd.wdata[15:0];
            st_d.tick_cnt = 24'h0;
            st_d.ms_cnt = 16'h0;
            st_d.guard_pend = 1'b0;
          end
          default: st_d.od_abort = 1'b1; // read-only or unknown
        endcase
      end
    end

    // new error after any clear, so a coincident clear keeps only the new entry
    if (err_evt)
    begin
      for (int i = cnse_pkg::HIST_DEPTH - 1; i > 0; i--)
      begin
        st_d.hist[i] = st_q.hist[i-1];
      end
      st_d.hist[0] = err_code;
      st_d.emcy_code = err_code;
      if (st_d.err_cnt != 4'(cnse_pkg::HIST_DEPTH))
        st_d.err_cnt = st_d.err_cnt + 4'h1;
      st_d.emcy_pend = 1'b1;
      st_d.err_evt = 1'b1;
    end

    // serial service port configuration
    if (cfg_wr)
    begin
      case (cfg_sel)
        cnse_pkg::CFG_NODE_ID:
        begin
          if (cfg_wdata[7] == 1'b0 && cfg_wdata[6:0] >= cnse_pkg::NODE_ID_MIN &&
              cfg_wdata[6:0] <= cnse_pkg::NODE_ID_MAX)
          begin
            st_d.node_id = cfg_wdata[6:0];
            st_d.cfg_ack = 1'b1;
          end
          else
            st_d.cfg_nak = 1'b1;
        end
        cnse_pkg::CFG_BITRATE:
        begin
          if (cfg_wdata < {4'h0, cnse_pkg::BITRATE_COUNT})
          begin
            st_d.bitrate = cfg_wdata[3:0];
            st_d.cfg_ack = 1'b1;
          end
          else
            st_d.cfg_nak = 1'b1;
        end
        cnse_pkg::CFG_SDO2_EN:
        begin
          st_d.sdo2_en = cfg_wdata[0];
          st_d.cfg_ack = 1'b1;
        end
        default: st_d.cfg_nak = 1'b1;
      endcase
    end

    // transmit: drop the frame once taken, else load the most urgent
    if (st_q.tx_valid && tx_ready)
    begin
      st_d.tx_valid = 1'b0;
    end
    else if (!st_q.tx_valid)
    begin
      st_d.tx_frame = '0;
      if (st_q.boot_pend)
      begin
        st_d.boot_pend = 1'b0;
        st_d.tx_valid = 1'b1;
        st_d.tx_frame.cob = errctl_id;
        st_d.tx_frame.dlc = 4'h1;
      end
      else if (st_q.emcy_pend && st_q.state != cnse_pkg::ST_STOPPED &&
               st_q.state != cnse_pkg::ST_INIT)
      begin
        st_d.emcy_pend = err_evt;
        st_d.tx_valid = 1'b1;
        st_d.tx_frame.cob = emcy_id;
        st_d.tx_frame.dlc = 4'h8;
        st_d.tx_frame.data[23:0] = {7'h0, generic_err, st_q.emcy_code[15:8],
                                    st_q.emcy_code[7:0]};
      end
      else if (st_q.guard_pend)
      begin
        st_d.guard_pend = 1'b0;
        st_d.toggle = ~st_q.toggle;
        st_d.tx_valid = 1'b1;
        st_d.tx_frame.cob = errctl_id;
        st_d.tx_frame.dlc = 4'h1;
        st_d.tx_frame.data[7:0] = {st_q.toggle, 4'h0, st_q.state};
      end
      else if (st_q.hb_pend)
      begin
        st_d.hb_pend = 1'b0;
        st_d.tx_valid = 1'b1;
        st_d.tx_frame.cob = errctl_id;
        st_d.tx_frame.dlc = 4'h1;
        st_d.tx_frame.data[7:0] = {5'h0, st_q.state};
      end
    end

    // status word: state code low, error copy in bit seven, rest zero
    st_d.status = 32'h0;
    st_d.status[2:0] = st_d.state;
    st_d.status[cnse_pkg::STATUS_ERR_BIT] = (st_d.err_cnt != 4'h0);
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.state <= cnse_pkg::ST_INIT;
      st_q.hb_time <= cnse_pkg::HB_TIME_RESET;
      st_q.node_id <= cnse_pkg::NODE_ID_DEFAULT;
      st_q.bitrate <= cnse_pkg::BITRATE_DEFAULT;
      st_q.sdo2_en <= 1'b1;
      st_q.status <= cnse_pkg::STATUS_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_frame = st_q.tx_frame;
  assign tx_valid = st_q.tx_valid;
  assign od_ack = st_q.od_ack;
  assign od_abort = st_q.od_abort;
  assign od_rdata = st_q.od_rdata;
  assign cfg_ack = st_q.cfg_ack;
  assign cfg_nak = st_q.cfg_nak;
  assign node_id = st_q.node_id;
  assign bitrate_sel = st_q.bitrate;
  assign sdo2_enable = st_q.sdo2_en;
  // channel counts are fixed; transfers themselves live in the server engine
  assign sdo_channels = 2'(cnse_pkg::SDO_CHANNELS);
  assign tpdo_channels = 3'(cnse_pkg::TPDO_CHANNELS);
  assign rpdo_channels = 2'(cnse_pkg::RPDO_CHANNELS);
  assign sync_pulse = st_q.sync_pulse;
  assign err_tpdo_evt = st_q.err_evt;
  assign status_word = st_q.status;

endmodule

// File: cnse_node_monitor.sv
// concurrent checks on the node status and emergency block ports
module cnse_node_checker #(
  parameter int HB_TICK_CYCLES = cnse_pkg::HB_UNIT_CYCLES // cycles per heartbeat ms
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input cnse_pkg::cnse_frame_type rx_frame,
  input cnse_pkg::cnse_frame_type tx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic od_req,
  input cnse_pkg::cnse_od_req_type od_cmd,
  input wire logic od_ack,
  input wire logic od_abort,
  input wire logic [31:0] od_rdata,
  input wire logic err_evt,
  input wire logic [6:0] node_id,
  input wire logic err_tpdo_evt,
  input wire logic [31:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_dev_type;
    od_req && !od_cmd.wr && od_cmd.index == cnse_pkg::IDX_DEVICE_TYPE
      |=> od_ack && !od_abort && od_rdata == 32'h0;
  endproperty
  a_dev_type: assert property (p_dev_type)
    else $error("device type read not zero");
  property p_status_bits;
    status_word[31:8] == 24'h0 && status_word[6:3] == 4'h0
      && status_word[2:0] inside {3'h0, 3'h5, 3'h6, 3'h7};
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status word has illegal bits");
  property p_err_event;
    err_evt |=> err_tpdo_evt;
  endproperty
  a_err_event: assert property (p_err_event)
    else $error("error event not passed to process data");
  property p_err_mirror;
    err_evt |=> ##[0:2] status_word[7];
  endproperty
  a_err_mirror: assert property (p_err_mirror)
    else $error("status error bit not set after error");
  property p_nmt_start;
    rx_valid && !rx_frame.rtr && rx_frame.cob == cnse_pkg::NMT_COB
      && rx_frame.data[7:0] == cnse_pkg::NMT_START && rx_frame.data[15:8] == {1'b0, node_id}
      && status_word[2:0] == 3'h5 |=> status_word[2:0] == 3'h6;
  endproperty
  a_nmt_start: assert property (p_nmt_start)
    else $error("start command did not enter operational");
  property p_no_sync_out;
    tx_valid |-> tx_frame.cob != cnse_pkg::SYNC_COB;
  endproperty
  a_no_sync_out: assert property (p_no_sync_out)
    else $error("node produced a synchronisation frame");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("frame dropped or changed while stalled");
  property p_boot;
    $rose(rst_n) |-> ##[1:3] tx_valid && tx_frame.dlc == 4'h1
      && tx_frame.cob == cnse_pkg::ERRCTL_COB_BASE + 11'(node_id);
  endproperty
  a_boot: assert property (p_boot)
    else $error("no boot-up frame after reset");
endmodule

bind cnse_node cnse_node_checker #(.HB_TICK_CYCLES(HB_TICK_CYCLES)) i_chk (
  .ref_clk, .rst_n, .rx_valid, .rx_frame, .tx_frame, .tx_valid, .tx_ready, .od_req,
  .od_cmd, .od_ack, .od_abort, .od_rdata, .err_evt, .node_id, .err_tpdo_evt, .status_word);

// File: cnse_master.sv
// behavioural field-bus master: sends frames to the node and sinks its frames
module cnse_master (
  input wire logic ref_clk,
  output logic rx_valid,
  output cnse_pkg::cnse_frame_type rx_frame,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall = 1'b0; // random back-pressure when set

  // idle bus after time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b1;
  end

  // sink readiness moves only at the falling edge
  always @(negedge ref_clk)
    tx_ready <= stall ? 1'($urandom % 2) : 1'b1;

  // one frame for one cycle; a released bus does not keep the last frame
  task automatic send(input logic rtr, input logic [10:0] cob, input logic [3:0] dlc,
                      input logic [63:0] data);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_frame = '{rtr, cob, dlc, data};
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_frame = ~rx_frame;
  endtask

  // network-management command on the fixed identifier
  task automatic nmt(input logic [7:0] cmd, input logic [7:0] target);
    send(1'b0, cnse_pkg::NMT_COB, 4'h2, {48'h0, target, cmd});
  endtask
endmodule

// File: cnse_node_tb.sv
// self-checking testbench of the node status and emergency block
module cnse_node_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4; // shortened heartbeat millisecond
  logic ref_clk, rst_n, od_req, od_ack, od_abort, err_evt, cfg_wr, cfg_ack, cfg_nak;
  logic rx_valid, tx_valid, tx_ready, sdo2_enable, sync_pulse, err_tpdo_evt;
  logic [31:0] od_rdata, status_word;
  logic [15:0] err_code, code1, code2;
  logic [10:0] ecob; // error control identifier of the node
  logic [7:0] cfg_wdata;
  logic [6:0] node_id, id;
  logic [3:0] bitrate_sel;
  logic [2:0] tpdo_channels;
  logic [1:0] sdo_channels, rpdo_channels;
  cnse_pkg::cnse_frame_type rx_frame, tx_frame, exp_f;
  cnse_pkg::cnse_od_req_type od_cmd;
  cnse_pkg::cnse_cfg_sel_type cfg_sel;
  int fails, total_checks, cyc;
  logic [32:0] q_od[$]; // expected abort flag and read data
  cnse_pkg::cnse_frame_type q_tx[$]; // expected frames in send order
  logic [7:0] cmds[5] = '{8'h01, 8'h02, 8'h80, 8'h82, 8'h81};
  logic [2:0] states[5] = '{3'h6, 3'h7, 3'h5, 3'h5, 3'h5};

  cnse_node #(.HB_TICK_CYCLES(TICK)) i_dut (.ref_clk, .rst_n, .rx_valid, .rx_frame,
    .tx_frame, .tx_valid, .tx_ready, .od_req, .od_cmd, .od_ack, .od_abort, .od_rdata,
    .err_evt, .err_code, .cfg_wr, .cfg_sel, .cfg_wdata, .cfg_ack, .cfg_nak, .node_id,
    .bitrate_sel, .sdo2_enable, .sdo_channels, .tpdo_channels, .rpdo_channels,
    .sync_pulse, .err_tpdo_evt, .status_word);
  cnse_master i_master (.ref_clk, .rx_valid, .rx_frame, .tx_ready);

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a hang counts as a mismatch
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // error control frame with one data byte
  function automatic cnse_pkg::cnse_frame_type frm(input logic [10:0] cob, input logic [7:0] b0);
    return '{1'b0, cob, 4'h1, {56'h0, b0}};
  endfunction
  // object access; the answer is checked by the watcher below
  task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                    input logic [31:0] wdata, input logic abort, input logic [31:0] rdata);
    @(negedge ref_clk);
    od_req = 1'b1;
    od_cmd = '{wr, idx, sub, wdata};
    q_od.push_back({abort, rdata});
    @(negedge ref_clk);
    od_req = 1'b0;
  endtask
  // service port write, answered one cycle later
  task automatic cfg(input cnse_pkg::cnse_cfg_sel_type sel, input logic [7:0] d, input logic ok);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_sel = sel;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    check("cfg_answer", {cfg_ack, cfg_nak}, {ok, !ok});
  endtask
  // new error code; an emergency frame must follow
  task automatic raise(input logic [15:0] code, input logic [10:0] cob);
    @(negedge ref_clk);
    err_evt = 1'b1;
    err_code = code;
    q_tx.push_back('{1'b0, cob, 4'h8, {40'h0, 8'h01, code}});
    @(negedge ref_clk);
    err_evt = 1'b0;
    check("err_tpdo_evt", err_tpdo_evt, 1'b1);
  endtask
  // wait, bounded, until every expected answer was seen
  task automatic drain;
    int n;
    n = 0;
    while ((q_tx.size() > 0 || q_od.size() > 0) && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("drain", n < 400, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // watchers: oldest note against each result
  // ----------------------------------------------------------------
  always @(negedge ref_clk)
    if (od_ack === 1'b1)
      check("od_result", {od_abort, od_rdata}, q_od.size() > 0 ? q_od.pop_front() : 'x);
  always @(posedge ref_clk)
    if (rst_n && (tx_valid & tx_ready) === 1'b1)
    begin
      exp_f = q_tx.size() > 0 ? q_tx.pop_front() : 'x;
      check("tx_frame", tx_frame, exp_f);
    end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    od_req = 1'b0;
    od_cmd = '0;
    err_evt = 1'b0;
    err_code = 16'h0;
    cfg_wr = 1'b0;
    cfg_sel = cnse_pkg::CFG_NODE_ID;
    cfg_wdata = 8'h0;
    void'($urandom(32'h1e33));
    q_tx.push_back(frm(cnse_pkg::ERRCTL_COB_BASE + 11'(cnse_pkg::NODE_ID_DEFAULT), 8'h0));
    repeat (16) @(negedge ref_clk);
    check("status_reset", status_word, 32'h0);
    rst_n = 1'b1;
    drain();
    check("status_preop", status_word, 32'h5);
    od(0, cnse_pkg::IDX_DEVICE_TYPE, 8'h0, 32'h0, 0, 32'h0);
    od(1, cnse_pkg::IDX_DEVICE_TYPE, 8'h0, 32'h1, 1, 32'h0);
    od(0, cnse_pkg::IDX_BUS_STATUS, 8'h0, 32'h0, 0, 32'h5);
    od(1, cnse_pkg::IDX_BUS_STATUS, 8'h0, 32'h0, 1, 32'h0);
    od(0, cnse_pkg::IDX_ERROR_SUMMARY, 8'h0, 32'h0, 0, 32'h0);
    od(0, 16'h1234, 8'h0, 32'h0, 1, 32'h0); // unmapped index
    drain();
    $display("test registers done");
    cfg(cnse_pkg::CFG_NODE_ID, 8'h00, 0);
    cfg(cnse_pkg::CFG_NODE_ID, 8'h80, 0);
    cfg(cnse_pkg::CFG_NODE_ID, 8'h7f, 1);
    id = 7'(1 + $urandom % 127);
    ecob = cnse_pkg::ERRCTL_COB_BASE + 11'(id);
    cfg(cnse_pkg::CFG_NODE_ID, {1'b0, id}, 1);
    check("node_id", node_id, id);
    for (int r = 0; r < 10; r++)
      cfg(cnse_pkg::CFG_BITRATE, 8'(r), r < 9);
    check("bitrate", bitrate_sel, 4'h8);
    cfg(cnse_pkg::CFG_SDO2_EN, 8'h0, 1);
    check("channels", {sdo2_enable, sdo_channels, tpdo_channels, rpdo_channels}, 8'h52);
    $display("test config done");
    code1 = 16'($urandom);
    code2 = 16'($urandom);
    raise(code1, cnse_pkg::EMCY_COB_BASE + 11'(id));
    raise(code2, cnse_pkg::EMCY_COB_BASE + 11'(id));
    i_master.send(0, cnse_pkg::EMCY_COB_BASE + 11'(id), 4'h8, 64'h1234);
    i_master.send(0, cnse_pkg::SYNC_COB, 4'h0, 64'h0);
    check("sync_pulse", sync_pulse, 1'b1);
    od(0, cnse_pkg::IDX_ERROR_HISTORY, 8'h0, 32'h0, 0, 32'h2);
    od(0, cnse_pkg::IDX_ERROR_HISTORY, 8'h1, 32'h0, 0, {16'h0, code2});
    od(0, cnse_pkg::IDX_ERROR_HISTORY, 8'h2, 32'h0, 0, {16'h0, code1});
    od(0, cnse_pkg::IDX_ERROR_HISTORY, 8'h3, 32'h0, 1, 32'h0);
    od(0, cnse_pkg::IDX_ERROR_SUMMARY, 8'h0, 32'h0, 0, 32'h1);
    drain();
    check("status_err", status_word, 32'h85);
    od(1, cnse_pkg::IDX_ERROR_HISTORY, 8'h0, 32'h1, 1, 32'h0);
    od(1, cnse_pkg::IDX_ERROR_HISTORY, 8'h0, 32'h0, 0, 32'h0);
    od(0, cnse_pkg::IDX_ERROR_HISTORY, 8'h0, 32'h0, 0, 32'h0);
    od(0, cnse_pkg::IDX_ERROR_SUMMARY, 8'h0, 32'h0, 0, 32'h0);
    drain();
    repeat (2) @(negedge ref_clk);
    check("status_clear", status_word, 32'h5);
    $display("test emergency done");
    for (int g = 0; g < 3; g++)
    begin
      q_tx.push_back(frm(ecob, {g[0], 7'h5}));
      i_master.send(1, ecob, 4'h0, 64'h0);
      drain();
    end
    i_master.stall = 1'b1;
    repeat (3) q_tx.push_back(frm(ecob, 8'h05));
    od(1, cnse_pkg::IDX_HB_TIME, 8'h0, 32'h8, 0, 32'h0);
    od(0, cnse_pkg::IDX_HB_TIME, 8'h0, 32'h0, 0, 32'h8);
    i_master.send(1, ecob, 4'h0, 64'h0);
    drain();
    od(1, cnse_pkg::IDX_HB_TIME, 8'h0, 32'h0, 0, 32'h0);
    repeat (60) @(negedge ref_clk);
    i_master.stall = 1'b0;
    $display("test guard and heartbeat done");
    od(1, cnse_pkg::IDX_EMCY_COB, 8'h0, 32'h0f0, 0, 32'h0);
    raise(16'h6300, 11'h0f0);
    od(0, cnse_pkg::IDX_EMCY_COB, 8'h0, 32'h0, 0, 32'h0f0);
    drain();
    for (int k = 0; k < 5; k++)
    begin
      if (k > 2)
        q_tx.push_back(frm(ecob, 8'h0));
      i_master.nmt(cmds[k], k == 2 ? 8'h0 : {1'b0, id});
      drain();
      repeat (3) @(negedge ref_clk);
      check("nmt_state", status_word[2:0], states[k]);
    end
    i_master.nmt(cnse_pkg::NMT_START, 8'h80);
    repeat (3) @(negedge ref_clk);
    check("nmt_other", status_word[2:0], 3'h5);
    raise(16'h6300, cnse_pkg::EMCY_COB_BASE + 11'(id));
    od(0, cnse_pkg::IDX_ERROR_HISTORY, 8'h0, 32'h0, 0, 32'h1);
    drain();
    $display("test network management done");
    tally_and_finish();
  end
endmodule
